// ---- drm_pkg.sv ----
package drm_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [4:0] ADR_MEM = 5'h00;
    localparam logic [4:0] ADR_IO = 5'h04;
    localparam logic [4:0] ADR_CNT = 5'h08;
    localparam logic [4:0] ADR_CTRL = 5'h0C;
    localparam logic [4:0] ADR_STAT = 5'h10;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int C_SIZE = 0;
    localparam int C_SIGN = 1;
    localparam int C_RPT = 2;
    localparam int C_DIR = 3;
    localparam int C_SRC = 4;
    localparam int C_A_STEP = 8;
    localparam int C_B_STEP = 9;
    localparam int C_B_SIGN = 10;
    localparam int C_FULL = 16;
    localparam int C_SINGLE = 17;
    localparam int C_CLRSEL = 18;
    localparam int C_BLK = 19;
    localparam int C_IRQEN = 20;
    localparam int C_EN = 21;
    localparam logic [31:0] CTRL_MASK = 32'h003F07FF;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // ----------------------------------------
    // Activation source codes
    // ----------------------------------------
    localparam logic [3:0] SRC_TMR5 = 4'h5;
    localparam logic [3:0] SRC_ADC = 4'h6;
    localparam logic [3:0] SRC_SER_TX = 4'h7;
    localparam logic [3:0] SRC_SER_RX = 4'h8;
    localparam logic [3:0] SRC_EXT = 4'h9;

    // Upper byte of the short second address
    localparam logic [7:0] IO_UPPER = 8'hFF;

    // ----------------------------------------
    // Engine states and memory request
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WRITE = 3'b010,
        ST_SINGLE = 3'b011,
        ST_UPDATE = 3'b100
    } drm_state_t;

    typedef struct packed {
        logic [23:0] addr;
        logic we;
        logic word;
        logic [15:0] wdata;
    } drm_mreq_t;

endpackage

// ---- drm_sync2.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for a pin input
module drm_sync2 (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Level in and out
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;

    // Two flops, first read only by second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else if (ce_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end

    assign q_o = s2_r;
endmodule

// ---- drm_addr_step.sv ----
`timescale 1ns/1ps
// Steps a 24-bit address by 1 or 2, up or down, or holds it
module drm_addr_step (
    // Address in and out
    input wire logic [23:0] addr_i,
    output logic [23:0] addr_o,
    // Step control
    input wire logic en_i,
    input wire logic down_i,
    input wire logic word_i
);
    logic [23:0] inc;

    // Increment of 1 for bytes, 2 for words
    assign inc = word_i ? 24'h000002 : 24'h000001;
    assign addr_o = !en_i ? addr_i : (down_i ? addr_i - inc : addr_i + inc);
endmodule

// ---- drm_engine.sv ----
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module drm_engine (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Activation sources
    input wire logic [5:0] timer_match_i,
    input wire logic adc_end_i,
    input wire logic ser_tx_end_i,
    input wire logic ser_rx_end_i,
    input wire logic ext_req_i,
    // Memory bus master
    output logic mbus_req_o,
    output drm_pkg::drm_mreq_t mbus_o,
    input wire logic mbus_ack_i,
    input wire logic [15:0] mbus_rdata_i,
    // Strobes and events
    output logic xfer_ack_strobe_n_o,
    output logic end_irq_o,
    output logic src_clear_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    drm_pkg::drm_state_t state_r, state_nxt;
    drm_pkg::drm_mreq_t mreq_r, mreq_nxt;
    logic [23:0] mem_r, mem_nxt, io_r, io_nxt;
    logic [15:0] cnt_r, cnt_nxt, data_r, data_nxt;
    logic [31:0] ctrl_r, ctrl_nxt, dat_r, dat_nxt;
    logic pend_r, pend_nxt, mv_r, mv_nxt, stb_n_r, stb_n_nxt;
    logic irq_r, irq_nxt, clr_r, clr_nxt, ack_r, ack_nxt;
    logic ext_s, req_sel, wb_wr;
    logic en, normal, short_m, rpt_mode, idle_mode, single, word, dir, ok;
    logic [23:0] sec_addr, src_addr, dst_addr, a_step, b_step, span;
    logic [8:0] hold9;
    logic [15:0] cnt_dec;
    logic [7:0] run_dec;

    // External request pin synchroniser
    drm_sync2 u_ext_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(ext_req_i),
        .q_o(ext_s)
    );

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    assign en = ctrl_r[drm_pkg::C_EN];
    assign word = ctrl_r[drm_pkg::C_SIZE];
    assign dir = ctrl_r[drm_pkg::C_DIR];
    assign normal = ctrl_r[drm_pkg::C_FULL] & ~ctrl_r[drm_pkg::C_BLK];
    assign short_m = ~ctrl_r[drm_pkg::C_FULL];
    assign ok = normal | short_m;
    assign rpt_mode = short_m & ctrl_r[drm_pkg::C_RPT]
                      & ~ctrl_r[drm_pkg::C_IRQEN];
    assign idle_mode = short_m & ctrl_r[drm_pkg::C_RPT]
                       & ctrl_r[drm_pkg::C_IRQEN];
    // single address only in short mode
    assign single = short_m & ctrl_r[drm_pkg::C_SINGLE];
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

    assign sec_addr = short_m ? {drm_pkg::IO_UPPER, io_r[15:0]} : io_r;
    assign src_addr = (short_m & dir) ? sec_addr : mem_r;
    assign dst_addr = normal ? io_r : (dir ? mem_r : sec_addr);

    // ----------------------------------------
    // Address steppers
    // ----------------------------------------
    // step by size and sign
    drm_addr_step u_step_a (
        .addr_i(mem_r),
        .addr_o(a_step),
        .en_i(normal ? ctrl_r[drm_pkg::C_A_STEP] : ~idle_mode),
        .down_i(ctrl_r[drm_pkg::C_SIGN]),
        .word_i(word)
    );
    drm_addr_step u_step_b (
        .addr_i(io_r),
        .addr_o(b_step),
        .en_i(ctrl_r[drm_pkg::C_B_STEP]),
        .down_i(ctrl_r[drm_pkg::C_B_SIGN]),
        .word_i(word)
    );

    // hold of zero counts as 256
    assign hold9 = {cnt_r[15:8] == 8'h00, cnt_r[15:8]};
    assign span = word ? {14'h0000, hold9, 1'b0} : {15'h0000, hold9};
    assign cnt_dec = cnt_r - 16'h0001;
    assign run_dec = cnt_r[7:0] - 8'h01;

    always_comb begin
        case (ctrl_r[drm_pkg::C_SRC +: 4])
            drm_pkg::SRC_ADC: req_sel = adc_end_i;
            drm_pkg::SRC_SER_TX: req_sel = ser_tx_end_i;
            drm_pkg::SRC_SER_RX: req_sel = ser_rx_end_i;
            drm_pkg::SRC_EXT: req_sel = ext_s;
            default: begin
                if (ctrl_r[drm_pkg::C_SRC +: 4] <= drm_pkg::SRC_TMR5) begin
                    req_sel = timer_match_i[ctrl_r[drm_pkg::C_SRC +: 3]];
                end else begin
                    req_sel = 1'b0;
                end
            end
        endcase
    end

    // Byte-lane merge for bus writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        mreq_nxt = mreq_r;
        mem_nxt = mem_r;
        io_nxt = io_r;
        cnt_nxt = cnt_r;
        data_nxt = data_r;
        ctrl_nxt = ctrl_r;
        mv_nxt = mv_r;
        stb_n_nxt = stb_n_r;
        irq_nxt = 1'b0;
        clr_nxt = 1'b0;
        dat_nxt = dat_r;
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        // latch one request, set wins over clear
        pend_nxt = en & (req_sel | (pend_r & (state_r != drm_pkg::ST_UPDATE)));
        case (state_r)
            drm_pkg::ST_IDLE: begin
                if (en & pend_r & ok) begin
                    mv_nxt = 1'b1;
                    mreq_nxt.word = word;
                    mreq_nxt.wdata = 16'h0000;
                    if (single) begin
                        mreq_nxt.addr = mem_r;
                        mreq_nxt.we = dir;
                        stb_n_nxt = 1'b0;
                        state_nxt = drm_pkg::ST_SINGLE;
                    end else begin
                        mreq_nxt.addr = src_addr;
                        mreq_nxt.we = 1'b0;
                        state_nxt = drm_pkg::ST_READ;
                    end
                end
            end
            drm_pkg::ST_READ: begin
                if (mbus_ack_i) begin
                    data_nxt = mbus_rdata_i;
                    mreq_nxt.addr = dst_addr;
                    mreq_nxt.we = 1'b1;
                    mreq_nxt.wdata = mbus_rdata_i;
                    state_nxt = drm_pkg::ST_WRITE;
                end
            end
            drm_pkg::ST_WRITE, drm_pkg::ST_SINGLE: begin
                if (mbus_ack_i) begin
                    mv_nxt = 1'b0;
                    stb_n_nxt = 1'b1;
                    state_nxt = drm_pkg::ST_UPDATE;
                end
            end
            drm_pkg::ST_UPDATE: begin
                state_nxt = drm_pkg::ST_IDLE;
                clr_nxt = ctrl_r[drm_pkg::C_CLRSEL];
                if (normal) begin
                    mem_nxt = a_step;
                    io_nxt = b_step;
                    cnt_nxt = cnt_dec;
                end else if (rpt_mode) begin
                    cnt_nxt[7:0] = run_dec;
                    mem_nxt = a_step;
                    if (run_dec == 8'h00) begin
                        cnt_nxt[7:0] = cnt_r[15:8];
                        mem_nxt = ctrl_r[drm_pkg::C_SIGN] ? a_step + span
                                                          : a_step - span;
                    end
                end else begin
                    mem_nxt = a_step;
                    cnt_nxt = cnt_dec;
                end
                if (!rpt_mode && cnt_dec == 16'h0000) begin
                    ctrl_nxt[drm_pkg::C_EN] = 1'b0;
                    irq_nxt = ctrl_r[drm_pkg::C_IRQEN];
                end
            end
            default: state_nxt = drm_pkg::ST_IDLE;
        endcase
        // Register reads
        if (wb_cyc_i & wb_stb_i & ~ack_r) begin
            case (wb_adr_i)
                drm_pkg::ADR_MEM: dat_nxt = {8'h00, mem_r};
                drm_pkg::ADR_IO: dat_nxt = {8'h00, io_r};
                drm_pkg::ADR_CNT: dat_nxt = {16'h0000, cnt_r};
                drm_pkg::ADR_CTRL: dat_nxt = ctrl_r;
                drm_pkg::ADR_STAT: dat_nxt = {25'h0000000, normal, rpt_mode,
                                              idle_mode, pend_r, state_r};
                default: dat_nxt = 32'h00000000;
            endcase
        end
        if (wb_wr) begin
            case (wb_adr_i)
                drm_pkg::ADR_MEM: mem_nxt = 24'(merge({8'h00, mem_r},
                                                      wb_dat_i, wb_sel_i));
                drm_pkg::ADR_IO: io_nxt = 24'(merge({8'h00, io_r}, wb_dat_i,
                                                    wb_sel_i));
                drm_pkg::ADR_CNT: cnt_nxt = 16'(merge({16'h0000, cnt_r},
                                                      wb_dat_i, wb_sel_i));
                drm_pkg::ADR_CTRL: ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i)
                                              & drm_pkg::CTRL_MASK;
                default: ;
            endcase
        end
    end

    // Registers, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= drm_pkg::ST_IDLE;
            mreq_r <= '0;
            mem_r <= drm_pkg::ADDR_RST;
            io_r <= drm_pkg::ADDR_RST;
            cnt_r <= drm_pkg::CNT_RST;
            data_r <= 16'h0000;
            ctrl_r <= drm_pkg::CTRL_RST;
            pend_r <= 1'b0;
            mv_r <= 1'b0;
            stb_n_r <= 1'b1;
            irq_r <= 1'b0;
            clr_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else if (ce_i) begin
            state_r <= state_nxt;
            mreq_r <= mreq_nxt;
            mem_r <= mem_nxt;
            io_r <= io_nxt;
            cnt_r <= cnt_nxt;
            data_r <= data_nxt;
            ctrl_r <= ctrl_nxt;
            pend_r <= pend_nxt;
            mv_r <= mv_nxt;
            stb_n_r <= stb_n_nxt;
            irq_r <= irq_nxt;
            clr_r <= clr_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign mbus_req_o = mv_r;
    assign mbus_o = mreq_r;
    assign xfer_ack_strobe_n_o = stb_n_r;
    assign end_irq_o = irq_r;
    assign src_clear_o = clr_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence s_upd_rpt;
        state_r == drm_pkg::ST_UPDATE && rpt_mode && !wb_wr;
    endsequence
    sequence s_read_done;
        state_r == drm_pkg::ST_READ && mbus_ack_i;
    endsequence

    a_run_reload: assert property (
        s_upd_rpt ##0 cnt_r[7:0] == 8'h01 |=>
            cnt_r[7:0] == $past(cnt_r[15:8]) && cnt_r[15:8] == $past(cnt_r[15:8]))
        else $error("running byte did not reload from hold");
    a_run_dec: assert property (
        s_upd_rpt ##0 cnt_r[7:0] != 8'h01 |=> cnt_r[7:0] == $past(run_dec))
        else $error("running byte did not decrement");
    a_rpt_no_irq: assert property (
        s_upd_rpt |=> !end_irq_o && ctrl_r[drm_pkg::C_EN] == $past(en))
        else $error("repeat mode ended or raised interrupt");
    a_off_quiet: assert property (
        !en && state_r == drm_pkg::ST_IDLE |=> state_r == drm_pkg::ST_IDLE
            && !mbus_req_o && !pend_r)
        else $error("disabled channel started a cycle");
    a_io_upper: assert property (
        state_r == drm_pkg::ST_READ && short_m && dir && !wb_wr |->
            mbus_o.addr[23:16] == drm_pkg::IO_UPPER)
        else $error("second address upper byte not ones");
    a_strobe_one: assert property (
        !xfer_ack_strobe_n_o == (state_r == drm_pkg::ST_SINGLE))
        else $error("strobe not tied to the single cycle");
    a_single_dir: assert property (
        state_r == drm_pkg::ST_SINGLE |-> mbus_o.we == dir
            && mbus_o.addr == mem_r)
        else $error("single mode direction wrong");
    a_dual_order: assert property (
        s_read_done ##0 !wb_wr |=> state_r == drm_pkg::ST_WRITE && mbus_o.we
            && mbus_o.wdata == $past(mbus_rdata_i))
        else $error("write did not follow read");
    a_norm_end: assert property (
        state_r == drm_pkg::ST_UPDATE && normal && cnt_r == 16'h0001
            && !wb_wr |=> !en && end_irq_o == $past(ctrl_r[drm_pkg::C_IRQEN]))
        else $error("normal end not handled");
    a_norm_dec: assert property (
        state_r == drm_pkg::ST_UPDATE && normal && !wb_wr |=>
            cnt_r == $past(cnt_dec) ##1 state_r != drm_pkg::ST_UPDATE)
        else $error("channel A counter did not decrement");
endmodule

// ---- drm_mem_model.sv ----
`timescale 1ns/1ps
module drm_mem_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Memory bus
    input wire logic req_i,
    input drm_pkg::drm_mreq_t mreq_i,
    input wire logic [1:0] delay_i,
    output logic ack_o,
    output logic [15:0] rdata_o,
    // Acknowledge strobe
    input wire logic strobe_n_i,
    output logic [7:0] strobes_o
);
    logic [1:0] wait_r;
    logic [15:0] last_r;
    logic strobe_q;
    // Read data only valid with ack, else scrambled
    assign rdata_o = ack_o ? {mreq_i.addr[7:0] ^ 8'h5A, mreq_i.addr[15:8]}
                           : ~last_r;
    // One-cycle ack after a chosen wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_r <= 2'h0;
            last_r <= 16'h0000;
        end else if (ack_o) begin
            ack_o <= 1'b0;
            wait_r <= delay_i;
            last_r <= rdata_o;
        end else if (req_i && wait_r == 2'h0) begin
            ack_o <= 1'b1;
        end else if (req_i) begin
            wait_r <= wait_r - 2'h1;
        end
    end
    // external device answers each strobe once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_q <= 1'b1;
            strobes_o <= 8'h00;
        end else begin
            strobe_q <= strobe_n_i;
            if (strobe_q && !strobe_n_i) begin
                strobes_o <= strobes_o + 8'h01;
            end
        end
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [4:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [5:0] tmr;
    logic [3:0] sel_v;
    logic adc, stx, srx, ext, mreq, mack, strobe_n, irq, srcclr;
    logic [1:0] mdly;
    logic [15:0] mrdata;
    logic [7:0] strobes;
    drm_pkg::drm_mreq_t mbus;
    drm_pkg::drm_mreq_t log[$];
    int fails = 0;
    int total_checks = 0;
    int irqs = 0;
    int clrs = 0;
    localparam logic [31:0] EN = 32'h1 << drm_pkg::C_EN;
    localparam logic [31:0] CLR = 32'h1 << drm_pkg::C_CLRSEL;
    localparam logic [31:0] RPT = 32'h1 << drm_pkg::C_RPT;
    localparam logic [31:0] IRQ = 32'h1 << drm_pkg::C_IRQEN;
    localparam logic [31:0] SGL = 32'h1 << drm_pkg::C_SINGLE;
    localparam logic [31:0] FUL = 32'h1 << drm_pkg::C_FULL;

    drm_engine uut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .timer_match_i(tmr),
        .adc_end_i(adc), .ser_tx_end_i(stx), .ser_rx_end_i(srx),
        .ext_req_i(ext), .mbus_req_o(mreq), .mbus_o(mbus),
        .mbus_ack_i(mack), .mbus_rdata_i(mrdata),
        .xfer_ack_strobe_n_o(strobe_n), .end_irq_o(irq),
        .src_clear_o(srcclr));
    drm_mem_model mem (.clk_i(clk), .rst_i(rst), .req_i(mreq),
        .mreq_i(mbus), .delay_i(mdly), .ack_o(mack), .rdata_o(mrdata),
        .strobe_n_i(strobe_n), .strobes_o(strobes));

    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Log completed memory cycles and interrupts
    always @(posedge clk) begin
        if (mreq === 1'b1 && mack === 1'b1) log.push_back(mbus);
        if (irq === 1'b1) irqs++;
        if (srcclr === 1'b1) clrs++;
    end

    function automatic logic [15:0] pat(input logic [23:0] a);
        return {a[7:0] ^ 8'h5A, a[15:8]};
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= sel_v;
        wb_adr <= a;
        wb_dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) chk(0, 1, "bus timeout");
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, "register read");
    endtask

    // Pulse one activation source
    task automatic fire(input logic [3:0] s);
        mdly <= 2'($urandom);
        if (s < 6) tmr[s] <= 1'b1;
        adc <= (s == 6);
        stx <= (s == 7);
        srx <= (s == 8);
        ext <= (s == 9);
        @(posedge clk);
        tmr <= 6'h00;
        {adc, stx, srx, ext} <= 4'h0;
    endtask

    task automatic wait_xfer(input int n);
        int k;
        k = 0;
        while (log.size() < n && k < 100) begin
            @(posedge clk);
            k++;
        end
        if (k >= 100) chk(0, 1, "transfer timeout");
        repeat (4) @(posedge clk);
    endtask

    task automatic run_repeat(input logic [3:0] s, input logic z, sg, d,
                              input logic big);
        logic [23:0] m, a, io;
        logic [23:0] r, w, st;
        logic [7:0] n;
        logic [31:0] c;
        int i0, c0, nn;
        m = 24'($urandom);
        io = 24'($urandom);
        // Zero in both bytes stands for 256 transfers
        n = big ? 8'h00 : 8'(2 + $urandom % 3);
        nn = (n == 8'h00) ? 256 : int'(n);
        st = z ? 24'h000002 : 24'h000001;
        i0 = irqs;
        c0 = clrs;
        c = ({28'h0, s} << drm_pkg::C_SRC) | RPT | {28'h0, d, 1'b0, sg, z};
        wr(drm_pkg::ADR_CTRL, CLR);
        wr(drm_pkg::ADR_MEM, {8'h00, m});
        wr(drm_pkg::ADR_IO, {8'h00, io});
        wr(drm_pkg::ADR_CNT, {16'h0, n, n});
        wr(drm_pkg::ADR_CTRL, CLR | c);
        rd(drm_pkg::ADR_CTRL, CLR | c);
        wr(drm_pkg::ADR_CTRL, CLR | c | EN);
        a = m;
        for (int i = 0; i < nn + 3; i++) begin
            log.delete();
            if (i == nn + 1) begin
                wr(drm_pkg::ADR_CTRL, CLR | c);
                fire(s);
                repeat (10) @(posedge clk);
                chk(log.size(), 0, "disabled moved");
                wr(drm_pkg::ADR_CTRL, CLR | c | EN);
                log.delete();
            end
            fire(s);
            wait_xfer(2);
            r = d ? {8'hFF, io[15:0]} : a;
            w = d ? a : {8'hFF, io[15:0]};
            chk(log[0].addr, r, "read addr");
            chk(log[1].addr, w, "write addr");
            chk(log[1].wdata, pat(r), "write data");
            chk(log[0].word, z, "size bit");
            // Address winds back after every nn transfers
            a = (i % nn == nn - 1) ? m : (sg ? a - st : a + st);
        end
        rd(drm_pkg::ADR_CNT, {16'h0, n, 8'(nn - (nn + 3) % nn)});
        rd(drm_pkg::ADR_MEM, {8'h00, a});
        chk(irqs, i0, "repeat irq");
        chk(clrs - c0, nn + 3, "clear pulses");
        wr(drm_pkg::ADR_CTRL, 32'h0);
        $display("test repeat source %0d done", s);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        final_report;
    end

    initial begin
        logic [23:0] a, b;
        logic [31:0] c;
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, adc, stx, srx, ext} = 7'h0;
        wb_adr = 5'h00;
        wb_sel = 4'hF;
        wb_dat_w = 32'h0;
        tmr = 6'h00;
        sel_v = 4'hF;
        mdly = 2'h0;
        void'($urandom(23));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(drm_pkg::ADR_CTRL, drm_pkg::CTRL_RST);
        rd(drm_pkg::ADR_STAT, 32'h0);
        rd(5'h14, 32'h0);
        // Byte lanes honoured on a partial write, upper bits read 0
        wr(drm_pkg::ADR_MEM, 32'hFFFFFFFF);
        sel_v = 4'h2;
        wr(drm_pkg::ADR_MEM, 32'h12AB34CD);
        sel_v = 4'hF;
        rd(drm_pkg::ADR_MEM, 32'h00FF34FF);
        for (int s = 0; s < 10; s++)
            run_repeat(4'(s), 1'($urandom), 1'($urandom), 1'($urandom),
                       s == 3);
        // Single address mode, both directions
        for (int d = 0; d < 2; d++) begin
            a = 24'($urandom);
            b = a;
            c = ({28'h0, 4'h9} << drm_pkg::C_SRC) | IRQ | (d << 3) | 32'h1;
            wr(drm_pkg::ADR_CTRL, SGL);
            wr(drm_pkg::ADR_MEM, {8'h00, a});
            wr(drm_pkg::ADR_CNT, 32'h2);
            wr(drm_pkg::ADR_CTRL, SGL | c | EN);
            for (int i = 0; i < 2; i++) begin
                log.delete();
                fire(4'h9);
                wait_xfer(1);
                chk(log.size(), 1, "single count");
                chk(log[0].addr, b, "single addr");
                chk(log[0].we, d[0], "single dir");
                b = b + 24'h2;
            end
            rd(drm_pkg::ADR_CTRL, SGL | c);
            $display("test single dir %0d done", d);
        end
        chk(strobes, 4, "strobe count");
        // Normal mode, A up by word, B down by word
        a = 24'($urandom);
        b = 24'($urandom);
        c = FUL | IRQ | 32'h701 | ({28'h0, 4'h6} << drm_pkg::C_SRC);
        wr(drm_pkg::ADR_CTRL, FUL);
        wr(drm_pkg::ADR_MEM, {8'h00, a});
        wr(drm_pkg::ADR_IO, {8'h00, b});
        wr(drm_pkg::ADR_CNT, 32'h3);
        wr(drm_pkg::ADR_CTRL, c | EN);
        irqs = 0;
        for (int i = 0; i < 4; i++) begin
            log.delete();
            fire(4'h6);
            wait_xfer(i < 3 ? 2 : 0);
            chk(log.size(), i < 3 ? 2 : 0, "normal count");
            if (i < 3) begin
                chk(log[0].addr, a, "normal src");
                chk(log[1].addr, b, "normal dst");
                chk(log[1].wdata, pat(a), "normal data");
            end
            a = a + 24'h2;
            b = b - 24'h2;
        end
        chk(irqs, 1, "normal irq");
        rd(drm_pkg::ADR_CTRL, c);
        rd(drm_pkg::ADR_CNT, 32'h0);
        $display("test normal done");
        final_report;
    end
endmodule
